// file: include/sbt_pkg.sv
/*
  Shared constants and types for the SRAM boundary-scan test access port.
  Assumes one package compiled before every design file.
*/
package sbt_pkg;
  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam int BSR_LENGTH = 107;
  localparam int OE_CELL = 47;
  localparam int RESET_TMS_EDGES = 5;
  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_IDCODE = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
  localparam logic [2:0] ID_REVISION = 3'h0;
  // Arbitrary neutral part and maker fields
  localparam logic [16:0] ID_PART = 17'h00A5A;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [31:0] ID_CODE = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};

  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } sbt_state_t;

  typedef struct packed {
    logic tdo;
    logic tdo_en;
  } sbt_tdo_t;
endpackage

// file: core/sbt_fsm.sv
/*
  TAP controller state machine, sixteen states, on the test clock.
  Assumes TMS already belongs to the test clock domain.
*/
`timescale 1ns/10ps
module sbt_fsm
(
  input wire logic tck,
  input wire logic rst,
  input wire logic tms,
  output sbt_pkg::sbt_state_t state
);
  sbt_pkg::sbt_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      sbt_pkg::ST_RESET: next_state = tms ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE: next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR: next_state = tms ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: next_state = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_SHIFT_DR: next_state = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_EXIT1_DR: next_state = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_PAUSE_DR: next_state = tms ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_EXIT2_DR: next_state = tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_UPD_DR: next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR: next_state = tms ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: next_state = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_SHIFT_IR: next_state = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_EXIT1_IR: next_state = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_PAUSE_IR: next_state = tms ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_EXIT2_IR: next_state = tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_UPD_IR: next_state = tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      default: next_state = sbt_pkg::ST_RESET;
    endcase
  end

  // Five high TMS edges reach reset from any state
  always_ff @(posedge tck)
  begin
    if (rst)
      state <= sbt_pkg::ST_RESET;
    else
      state <= next_state;
  end
endmodule

// file: core/sbt_tap.sv
/*
  Boundary-scan test access port for a synchronous SRAM: instruction,
  bypass, identification and boundary registers, output-bus control.
  Assumes SYS_RST is a power-up reset on CLK; the tester drives TCK.
*/
// Functional notes
// - Inputs sampled on rising TCK; TDO changes only on falling TCK.
// - Scan registers enter at MSB from TDI, leave LSB to TDO.
// - Five TMS-high edges reset the TAP without touching the SRAM.
// - Power-up reset puts TAP in reset with TDO high impedance.
// - Exactly one register between TDI and TDO, chosen by instruction.
// - Three-bit instruction register loads identification code on reset.
// - Capture-IR loads binary 01 into the two low bits.
// - Shifted instruction takes effect only at Update-IR.
// - Bypass is one bit, cleared when BYPASS executes.
// - BYPASS makes a single-bit path during Shift-DR.
// - Capture-DR loads pin states into boundary register, then shifts.
// - Identification instruction captures the hardwired 32-bit code.
// - High-impedance sample selects boundary register, tristates output bus.
// - Sample/preload snapshots pins without disturbing the SRAM.
// - Update-DR holds preload data; capture out and preload in together.
// - EXTEST drives preloaded values onto system outputs.
// - Cell 47 latched at Update-DR enables or tristates output under EXTEST.
// - Output-enable cell preset high at power-up and Test-Logic-Reset.
// - Codes: EXTEST 000, ID 001, Z 010, preload 100, bypass 111.
`timescale 1ns/10ps
module sbt_tap
#(
  parameter int BSR_LEN = sbt_pkg::BSR_LENGTH
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [BSR_LEN-1:0] PIN_STATE,
  input wire logic [BSR_LEN-1:0] FUNC_OUT,
  input wire logic FUNC_OUT_EN,
  output logic [BSR_LEN-1:0] PIN_OUT,
  output logic PIN_OUT_EN,
  output logic TEST_DRIVE
);
  // Power-up reset crosses to TCK as a level
  logic rst_meta;
  logic rst_sync;
  logic [3:0] rst_hold;
  logic tap_rst;
  logic rst_seen;
  logic rst_ack_meta;
  logic rst_ack;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      rst_hold <= 4'hF;
    else if (rst_ack && rst_hold != 4'h0)
      rst_hold <= rst_hold - 4'h1;
  end

  always_ff @(posedge CLK)
  begin
    rst_ack_meta <= rst_seen;
    rst_ack <= rst_ack_meta;
  end

  always_ff @(posedge TCK)
  begin
    rst_meta <= (rst_hold != 4'h0);
    rst_sync <= rst_meta;
    rst_seen <= rst_sync;
  end

  assign tap_rst = rst_sync;

  sbt_pkg::sbt_state_t state;

  sbt_fsm u_fsm
  (
    .tck(TCK),
    .rst(tap_rst),
    .tms(TMS),
    .state(state)
  );

  wire in_reset = (state == sbt_pkg::ST_RESET);
  wire cap_ir = (state == sbt_pkg::ST_CAP_IR);
  wire shift_ir = (state == sbt_pkg::ST_SHIFT_IR);
  wire upd_ir = (state == sbt_pkg::ST_UPD_IR);
  wire cap_dr = (state == sbt_pkg::ST_CAP_DR);
  wire shift_dr = (state == sbt_pkg::ST_SHIFT_DR);
  wire upd_dr = (state == sbt_pkg::ST_UPD_DR);

  logic [sbt_pkg::IR_WIDTH-1:0] ir_shift;
  logic [sbt_pkg::IR_WIDTH-1:0] ir;
  logic bypass;
  logic [sbt_pkg::ID_WIDTH-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_latch;

  wire sel_bypass = (ir == sbt_pkg::INSTR_BYPASS);
  wire sel_id = (ir == sbt_pkg::INSTR_IDCODE);
  wire sel_extest = (ir == sbt_pkg::INSTR_EXTEST);
  wire sel_z = (ir == sbt_pkg::INSTR_SAMPLE_Z);
  // Reserved codes fall to bypass so one register is always selected
  wire sel_bsr = sel_extest || sel_z || (ir == sbt_pkg::INSTR_SAMPLE_PRELOAD);

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
      ir_shift <= '0;
    else if (cap_ir)
      ir_shift <= {1'b0, sbt_pkg::IR_CAPTURE_PATTERN};
    else if (shift_ir)
      ir_shift <= {TDI, ir_shift[sbt_pkg::IR_WIDTH-1:1]};
  end

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
      ir <= sbt_pkg::INSTR_IDCODE;
    else if (upd_ir)
      ir <= ir_shift;
  end

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
      bypass <= 1'b0;
    else if (cap_dr && sel_bypass)
      bypass <= 1'b0;
    else if (shift_dr && !sel_id && !sel_bsr)
      bypass <= TDI;
  end

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
      id_shift <= '0;
    else if (cap_dr && sel_id)
      id_shift <= sbt_pkg::ID_CODE;
    else if (shift_dr && sel_id)
      id_shift <= {TDI, id_shift[sbt_pkg::ID_WIDTH-1:1]};
  end

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
      bsr_shift <= '0;
    else if (cap_dr && sel_bsr)
      bsr_shift <= PIN_STATE;
    else if (shift_dr && sel_bsr)
      bsr_shift <= {TDI, bsr_shift[BSR_LEN-1:1]};
  end

  always_ff @(posedge TCK)
  begin
    if (tap_rst || in_reset)
    begin
      bsr_latch <= '0;
      bsr_latch[sbt_pkg::OE_CELL] <= 1'b1;
    end
    else if (upd_dr && sel_bsr)
      bsr_latch <= bsr_shift;
  end

  // Serial output mux, one register at a time
  wire tdo_mux = shift_ir ? ir_shift[0] :
                 sel_id ? id_shift[0] :
                 sel_bsr ? bsr_shift[0] : bypass;

  always_ff @(negedge TCK)
  begin
    if (tap_rst)
    begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end
    else
    begin
      TDO <= tdo_mux;
      TDO_OE <= shift_ir || shift_dr;
    end
  end

  // Pin control: test values under EXTEST, output enable off under sel_z, else functional path
  wire oe_cell = bsr_latch[sbt_pkg::OE_CELL];
  assign TEST_DRIVE = sel_extest;
  assign PIN_OUT = sel_extest ? bsr_latch : FUNC_OUT;
  assign PIN_OUT_EN = sel_z ? 1'b0 :
                      sel_extest ? oe_cell : FUNC_OUT_EN;
endmodule

// file: sim/sbt_tap_chk.sv
/* Pin-level checker for the test access port.
   Bound into sbt_tap; sees its ports only. */
`timescale 1ns/10ps
module sbt_tap_chk
#(
  parameter int BSR_LEN = 107
)
(
  input wire logic SYS_RST,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic [BSR_LEN-1:0] FUNC_OUT,
  input wire logic FUNC_OUT_EN,
  input wire logic [BSR_LEN-1:0] PIN_OUT,
  input wire logic PIN_OUT_EN,
  input wire logic TEST_DRIVE
);
  default clocking tck_cb @(posedge TCK);
  endclocking
  default disable iff (SYS_RST);
  sequence tap_rst;
    TMS [*5];
  endsequence
  sequence to_sir;
    tap_rst ##1 !TMS ##1 TMS ##1 TMS ##1 !TMS ##1 !TMS;
  endsequence
  sequence to_sdr;
    tap_rst ##1 !TMS ##1 TMS ##1 !TMS ##1 !TMS;
  endsequence
  rst_oe_a: assert property (tap_rst |=> !TDO_OE)
    else $error("TDO driven after reset");
  rst_pins_a: assert property (tap_rst |=> !TEST_DRIVE && PIN_OUT_EN == FUNC_OUT_EN)
    else $error("pins not functional after reset");
  ir_cap_a: assert property (to_sir |=> TDO && TDO_OE)
    else $error("bad instruction capture bit");
  id_cap_a: assert property (to_sdr |=> TDO == sbt_pkg::ID_CODE[0] && TDO_OE)
    else $error("bad first id bit");
  id_shift_a: assert property (to_sdr ##1 !TMS |=> TDO == sbt_pkg::ID_CODE[1])
    else $error("bad second id bit");
  oe_rise_a: assert property ($rose(TDO_OE) |-> !$past(TMS) && !$past(TMS, 2))
    else $error("TDO enabled outside shift");
  oe_fall_a: assert property ($fell(TDO_OE) |-> $past(TMS))
    else $error("TDO released inside shift");
  func_out_a: assert property (!TEST_DRIVE |-> PIN_OUT == FUNC_OUT)
    else $error("outputs not functional");
  func_en_a: assert property (PIN_OUT_EN && !TEST_DRIVE |-> FUNC_OUT_EN)
    else $error("output bus enabled wrongly");
endmodule
bind sbt_tap sbt_tap_chk #(.BSR_LEN(BSR_LEN)) i_chk (.SYS_RST(SYS_RST), .TCK(TCK), .TMS(TMS),
  .TDO(TDO), .TDO_OE(TDO_OE), .FUNC_OUT(FUNC_OUT), .FUNC_OUT_EN(FUNC_OUT_EN),
  .PIN_OUT(PIN_OUT), .PIN_OUT_EN(PIN_OUT_EN), .TEST_DRIVE(TEST_DRIVE));

// file: sim/sbt_tester.sv
/* Tester model driving the scan pins.
   Assumes the device samples on rising tck and drives TDO on falling tck. */
`timescale 1ns/10ps
module sbt_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One clock; pins set while tck low, TDO taken at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #7.5 tck = 1'b1;
    q = tdo;
    #7.5 tck = 1'b0;
  endtask
  task automatic tap_reset(input int n);
    logic q;
    repeat (n) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // Idle to idle scan, LSB first; defined codes only
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tdi = 1'b1;
  endtask
endmodule

// file: sim/sbt_tap_test.sv
/* Bench for the test access port.
   Assumes sbt_pkg, the design and the tester model compiled first. */
`timescale 1ns/10ps
module sbt_tap_test;
  localparam int N = 107;
  logic clk, sys_rst, func_en, tck, tms, tdi, tdo, tdo_oe, pin_en, drive;
  logic [N-1:0] pin_state, func_out, pin_out, q;
  logic [127:0] so;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  sbt_tap #(.BSR_LEN(N)) i_dut (.CLK(clk), .SYS_RST(sys_rst), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .PIN_STATE(pin_state), .FUNC_OUT(func_out),
    .FUNC_OUT_EN(func_en), .PIN_OUT(pin_out), .PIN_OUT_EN(pin_en), .TEST_DRIVE(drive));
  sbt_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic ir(input logic [2:0] c);
    i_tester.scan(1'b1, 3, 128'(c), so);
    check(so & 128'h3, 128'h1, "ir capture");
  endtask
  task automatic dr(input int n, input logic [127:0] din, input logic [127:0] exp);
    i_tester.scan(1'b0, n, din, so);
    check(so & ((128'h1 << n) - 128'h1), exp, "scan out");
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    sys_rst = 1'b1;
    func_en = 1'b0;
    pin_state = {3'h5, {4{26'h2A5C3F1}}};
    func_out = ~{3'h5, {4{26'h2A5C3F1}}};
    q = {3'h2, {4{26'h1C3A596}}};
    q[47] = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    i_tester.tap_reset(80);
    ir(sbt_pkg::INSTR_EXTEST);
    check(128'(pin_out), 128'h8000_0000_0000, "preset latch");
    check(128'({pin_en, drive}), 128'h3, "extest enable");
    $display("preset test done");
    ir(sbt_pkg::INSTR_SAMPLE_PRELOAD);
    dr(N, 128'(q), 128'(pin_state));
    check(128'({pin_out ^ func_out, pin_en, drive}), 128'h0, "preload passive");
    ir(sbt_pkg::INSTR_EXTEST);
    check(128'({pin_out, pin_en}), 128'({q, 1'b0}), "extest drive");
    q[47] = 1'b1;
    dr(N, 128'(q), 128'(pin_state));
    check(128'({pin_out, pin_en}), 128'({q, 1'b1}), "extest update");
    $display("preload and extest test done");
    @(posedge clk) func_en <= 1'b1;
    ir(sbt_pkg::INSTR_SAMPLE_Z);
    check(128'({pin_en, drive}), 128'h0, "sample z");
    dr(N, 128'h0, 128'(pin_state));
    ir(sbt_pkg::INSTR_BYPASS);
    check(128'({pin_en, drive}), 128'h2, "bypass passive");
    dr(8, 128'hA5, 128'h4A);
    $display("sample z and bypass test done");
    i_tester.tap_reset(5);
    dr(32, 128'h0, 128'(sbt_pkg::ID_CODE));
    $display("reset and id test done");
    finish_test();
  end
endmodule
